// >>> core/sac_clk_div.sv
// Purpose: converter clock enable from the system clock
// Assumes: div_sel stable while run is high
// Notes: counter restarts whenever run drops, so ticks align to a sequence
`timescale 1ns/10ps
module sac_clk_div
  import sac_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  sac_div_if.gen div
);
  logic [3:0] cnt;
  wire logic [3:0] period_last = 4'((5'h2 << div.div_sel) - 5'h1);
  wire logic wrap = (cnt == period_last);

  assign div.tick = div.run && wrap;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn || !div.run || wrap)
      cnt <= 4'h0;
    else
      cnt <= cnt + 4'h1;
  end

  div_tick_gap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    div.tick |=> !div.tick) else $error("converter tick repeated");
  div_period_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (div.tick && div.div_sel == 2'h1) ##1 (div.run && div.div_sel == 2'h1) [*4]
    |-> div.tick) else $error("divide by four period wrong");
endmodule : sac_clk_div

// >>> core/sac_div_if.sv
// Purpose: link between sequencer and converter clock divider
// Assumes: single system clock
// Notes: tick is a one-cycle pulse per converter clock period
`timescale 1ns/10ps
interface sac_div_if;
  logic [1:0] div_sel;
  logic run;
  logic tick;
  modport gen (input div_sel, input run, output tick);
  modport user (output div_sel, output run, input tick);
endinterface : sac_div_if

// >>> core/sac_pkg.sv
// Purpose: shared constants and types for the converter sequencer
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: byte offsets are the register port addresses
package sac_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W = 12;
  localparam int NUM_CHAN = 4;
  // register offsets
  localparam logic [7:0] OFS_CONFIG = 8'ha9;
  localparam logic [7:0] OFS_CONTROL = 8'hce;
  localparam logic [7:0] OFS_CHAN_EN = 8'hc0;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hc1;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hc2;
  localparam logic [7:0] OFS_RESULT_BASE = 8'hc4;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [3:0] RST_CHAN_EN = 4'h0;
  localparam logic [0:0] RST_IRQ_MASK = 1'h0;
  // converter_config fields
  localparam int CFG_POWER_ON = 7;
  localparam int CFG_IRQ_EN = 5;
  localparam int CFG_GO = 4;
  localparam int CFG_JUSTIFY = 3;
  localparam int CFG_DIV_HI = 1;
  localparam int CFG_DIV_LO = 0;
  // converter_control fields
  localparam int CTL_AUX_HI = 7;
  localparam int CTL_AUX_LO = 6;
  localparam int CTL_HOLD_A = 5;
  localparam int CTL_HOLD_B = 4;
  localparam int CTL_REF_SEL = 3;
  localparam int CTL_AVG_HI = 2;
  localparam int CTL_AVG_LO = 0;
  // aux source codes
  localparam logic [1:0] AUX_TEMP = 2'h2;
  localparam logic [1:0] AUX_CORE = 2'h3;
  // conversion timing in converter clocks
  localparam logic [4:0] CONV_LAST = 5'h1f;
  localparam logic [4:0] SAR_SEED = 5'h12;
  localparam logic [11:0] SAR_MSB = 12'h800;
  localparam logic [3:0] BIT_TOP = 4'hb;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_CONV = 4'b0100,
    ST_DONE = 4'b1000
  } sac_state_t;
endpackage : sac_pkg

// >>> core/sac_result_fmt.sv
// Purpose: splits a 12-bit result into high and low bytes
// Assumes: justify level from converter_config
// Notes: purely combinational, read path registers it
`timescale 1ns/10ps
module sac_result_fmt
  import sac_pkg::*;
(
  input wire logic [RES_W-1:0] i_result,
  input wire logic i_justify_msb,
  output logic [7:0] o_high_byte,
  output logic [7:0] o_low_byte
);
  assign o_high_byte = i_justify_msb ? i_result[11:4] : {4'h0, i_result[11:8]};
  assign o_low_byte = i_justify_msb ? {i_result[3:0], 4'h0} : i_result[7:0];
endmodule : sac_result_fmt

// >>> core/sac_top.sv
// Purpose: control and sequencing of a 12-bit successive approximation converter
// Assumes: register port on the system clock, comparator output asynchronous
// Notes: analog parts (dac, comparator, track/hold, mux) sit outside
// Operation
// - each conversion takes 32 converter clocks, 12 bits
// - four channels, separate enables and result registers
// - trigger holds track/hold, then converts channels in turn
// - completion interrupt after last channel when enabled
// - power bit on activates, off powers down
// - writing go starts; cleared when sequence done
// - software go ignored during hardware sequence
// - msb justify: high 11..4, low 3..0 then 0000
// - lsb justify: high 0000 then 11..8, low 7..0
// - prescaler divides system clock by 2,4,8,16
// - aux source: pin, pin, temperature, core supply
// - internal aux source disconnects external pin
// - channel A hold enable 0 bypasses track/hold
// - hold enable 1: follow input, hold at start
// - reference select: main supply 0, core 1
`timescale 1ns/10ps
module sac_top
  import sac_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_hw_trig,
  input wire logic i_cmp_high,
  output logic o_irq,
  output logic o_power_on,
  output logic o_sample,
  output logic [NUM_CHAN-1:0] o_chan_sel,
  output logic [RES_W-1:0] o_dac_code,
  output logic o_hold_a,
  output logic o_hold_b,
  output logic o_bypass_a,
  output logic o_bypass_b,
  output logic o_ref_core,
  output logic o_aux_pin_connect,
  output logic o_aux_temp,
  output logic o_aux_core
);
  sac_state_t state;
  logic [7:0] cfg;
  logic [7:0] ctl;
  logic [NUM_CHAN-1:0] chan_en;
  logic irq_status;
  logic irq_mask;
  logic go;
  logic hw_run;
  logic [1:0] chan;
  logic [4:0] tick_cnt;
  logic [3:0] bit_ptr;
  logic [RES_W-1:0] code;
  logic [RES_W-1:0] result [NUM_CHAN];
  logic cmp_meta;
  logic cmp_sync;

  sac_div_if div ();

  sac_clk_div u_div (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .div(div.gen)
  );

  function automatic logic [2:0] next_chan(input logic [3:0] en, input logic [1:0] cur,
                                           input logic first);
    logic [2:0] r;
    r = 3'h4;
    for (int i = NUM_CHAN - 1; i >= 0; i--)
      if (en[i] && (first || i > int'(cur)))
        r = {1'b0, 2'(i)};
    return r;
  endfunction : next_chan

  // register decode
  wire logic wr_cfg = i_wr && (i_addr == OFS_CONFIG);
  wire logic wr_ctl = i_wr && (i_addr == OFS_CONTROL);
  wire logic wr_en = i_wr && (i_addr == OFS_CHAN_EN);
  wire logic wr_mask = i_wr && (i_addr == OFS_IRQ_MASK);
  wire logic rd_status = i_rd && (i_addr == OFS_IRQ_STATUS);
  // results sit in pairs from the base, high byte at the even address
  wire logic rd_result = (i_addr >= OFS_RESULT_BASE) && (i_addr <= OFS_RESULT_BASE + 8'h07);
  wire logic [1:0] rd_chan = 2'((i_addr - OFS_RESULT_BASE) >> 1);

  wire logic power_on = cfg[CFG_POWER_ON];
  wire logic idle = (state == ST_IDLE);
  wire logic busy = !idle;
  wire logic any_en = |chan_en;
  wire logic start_ok = power_on && idle && any_en;
  wire logic hw_start = i_hw_trig && start_ok;
  // hardware wins a tie, and a busy sequencer ignores both
  wire logic sw_start = wr_cfg && i_wdata[CFG_GO] && start_ok && !i_hw_trig;
  wire logic seq_done = (state == ST_DONE);
  wire logic done_evt = seq_done && cfg[CFG_IRQ_EN];
  wire logic conv_tick = (state == ST_CONV) && div.tick;
  wire logic last_tick = conv_tick && (tick_cnt == CONV_LAST);
  wire logic [2:0] first_ch = next_chan(chan_en, 2'h0, 1'b1);
  wire logic [2:0] after_ch = next_chan(chan_en, chan, 1'b0);

  assign div.div_sel = cfg[CFG_DIV_HI:CFG_DIV_LO];
  assign div.run = busy && power_on;

  // comparator comes from the analog side, so it is synchronised first
  always_ff @(posedge i_ref_clk)
  begin
    cmp_meta <= i_cmp_high;
    cmp_sync <= cmp_meta;
  end

  // configuration registers; go is owned by the sequencer
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      cfg <= RST_CONFIG;
      ctl <= RST_CONTROL;
      chan_en <= RST_CHAN_EN;
      irq_mask <= RST_IRQ_MASK[0];
    end
    else
    begin
      if (wr_cfg)
        cfg <= i_wdata & 8'hab;
      if (wr_ctl)
        ctl <= i_wdata;
      if (wr_en)
        chan_en <= i_wdata[NUM_CHAN-1:0];
      if (wr_mask)
        irq_mask <= i_wdata[0];
    end
  end

  // sticky completion flag: a read clears it, a new event wins the tie
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      irq_status <= 1'b0;
    else
      irq_status <= done_evt || (irq_status && !rd_status);
  end

  assign o_irq = irq_status && irq_mask;

  // go bit and the source of the running sequence
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn || !power_on || seq_done)
    begin
      go <= 1'b0;
      hw_run <= 1'b0;
    end
    else if (hw_start || sw_start)
    begin
      go <= 1'b1;
      hw_run <= hw_start;
    end
  end

  // sequencer
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn || !power_on)
    begin
      state <= ST_IDLE;
      chan <= 2'h0;
      tick_cnt <= 5'h0;
    end
    else
      case (state)
        ST_IDLE:
          if (hw_start || sw_start)
            state <= ST_HOLD;
        ST_HOLD:
          if (div.tick)
          begin
            tick_cnt <= 5'h0;
            chan <= first_ch[1:0];
            state <= first_ch[2] ? ST_DONE : ST_CONV;
          end
        ST_CONV:
          if (last_tick)
          begin
            tick_cnt <= 5'h0;
            chan <= after_ch[1:0];
            state <= after_ch[2] ? ST_DONE : ST_CONV;
          end
          else if (conv_tick)
            tick_cnt <= tick_cnt + 5'h1;
        ST_DONE:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
  end

  // binary search: seed the msb, then keep or drop one bit per converter clock
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      code <= 12'h0;
      bit_ptr <= 4'h0;
    end
    else if (conv_tick && tick_cnt == SAR_SEED)
    begin
      code <= SAR_MSB;
      bit_ptr <= BIT_TOP;
    end
    else if (conv_tick && tick_cnt > SAR_SEED && tick_cnt < CONV_LAST)
    begin
      code[bit_ptr] <= cmp_sync;
      if (bit_ptr != 4'h0)
        code[bit_ptr - 4'h1] <= 1'b1;
      bit_ptr <= bit_ptr - 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      for (int i = 0; i < NUM_CHAN; i++)
        result[i] <= 12'h0;
    else if (last_tick)
      result[chan] <= code;
  end

  // read path, data valid only in the cycle after the strobe
  logic [7:0] fmt_high;
  logic [7:0] fmt_low;

  sac_result_fmt u_fmt (
    .i_result(result[rd_chan]),
    .i_justify_msb(cfg[CFG_JUSTIFY]),
    .o_high_byte(fmt_high),
    .o_low_byte(fmt_low)
  );

  wire logic [7:0] cfg_view = {cfg[7:5], go, cfg[3:0]};
  wire logic [7:0] result_view = i_addr[0] ? fmt_low : fmt_high;
  wire logic [7:0] rd_mux =
    (i_addr == OFS_CONFIG) ? cfg_view :
    (i_addr == OFS_CONTROL) ? ctl :
    (i_addr == OFS_CHAN_EN) ? {4'h0, chan_en} :
    (i_addr == OFS_IRQ_STATUS) ? {7'h0, irq_status} :
    (i_addr == OFS_IRQ_MASK) ? {7'h0, irq_mask} :
    rd_result ? result_view : 8'h00;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn || !i_rd)
      o_rdata <= 8'h00;
    else
      o_rdata <= rd_mux;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      o_dac_code <= 12'h0;
    else
      o_dac_code <= code;
  end

  // analog steering
  wire logic holding = (state == ST_HOLD) || (state == ST_CONV);
  assign o_power_on = power_on;
  assign o_sample = (state == ST_CONV) && (tick_cnt <= SAR_SEED);
  assign o_chan_sel = (state == ST_CONV) ? 4'(4'h1 << chan) : 4'h0;
  assign o_bypass_a = !ctl[CTL_HOLD_A];
  assign o_bypass_b = !ctl[CTL_HOLD_B];
  assign o_hold_a = ctl[CTL_HOLD_A] && holding;
  assign o_hold_b = ctl[CTL_HOLD_B] && holding;
  assign o_ref_core = ctl[CTL_REF_SEL];
  assign o_aux_pin_connect = !ctl[CTL_AUX_HI];
  assign o_aux_temp = ctl[CTL_AUX_HI:CTL_AUX_LO] == AUX_TEMP;
  assign o_aux_core = ctl[CTL_AUX_HI:CTL_AUX_LO] == AUX_CORE;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  conv_count_a: assert property (conv_tick && tick_cnt != CONV_LAST && power_on |=>
    tick_cnt == $past(tick_cnt) + 5'h1) else $error("conversion count skipped");
  hold_first_a: assert property ($rose(state == ST_CONV) |-> $past(state == ST_HOLD))
    else $error("conversion began without hold");
  irq_raise_a: assert property (seq_done && cfg[CFG_IRQ_EN] && irq_mask |=> o_irq)
    else $error("completion interrupt missing");
  power_down_a: assert property (!power_on |=> idle && !go)
    else $error("sequencer ran while powered down");
  go_clear_a: assert property (seq_done |=> !go && idle)
    else $error("go not cleared at completion");
  hw_ignore_a: assert property (hw_run && busy && wr_cfg |=> hw_run || !busy)
    else $error("software start disturbed hardware run");
  msb_fmt_a: assert property (cfg[CFG_JUSTIFY] |-> fmt_low[3:0] == 4'h0)
    else $error("low nibble not zero");
  lsb_fmt_a: assert property (!cfg[CFG_JUSTIFY] |-> fmt_high[7:4] == 4'h0)
    else $error("high nibble not zero");
  aux_pin_a: assert property (ctl[CTL_AUX_HI] |-> !o_aux_pin_connect && !o_aux_temp == o_aux_core)
    else $error("external pin left connected");
  bypass_a_a: assert property (!ctl[CTL_HOLD_A] |-> o_bypass_a && !o_hold_a)
    else $error("channel a hold not bypassed");
  go_busy_a: assert property (busy && !seq_done |-> go)
    else $error("go reads zero while running");
endmodule : sac_top

// >>> test/sac_analog_model.sv
// Purpose: analog side of the converter: channel levels and comparator
// Assumes: ideal comparator, levels fixed per instance
// Notes: with no channel selected the output toggles, so a stale value is never seen
`timescale 1ns/10ps
module sac_analog_model
  import sac_pkg::*;
#(
  parameter logic [RES_W-1:0] LVL_A = 12'h5a3,
  parameter logic [RES_W-1:0] LVL_B = 12'hc7e,
  parameter logic [RES_W-1:0] LVL_C = 12'h111,
  parameter logic [RES_W-1:0] LVL_PIN_D = 12'h222,
  parameter logic [RES_W-1:0] LVL_TEMP = 12'h333,
  parameter logic [RES_W-1:0] LVL_CORE = 12'h444
)
(
  input wire logic i_ref_clk,
  input wire logic [NUM_CHAN-1:0] i_chan_sel,
  input wire logic [RES_W-1:0] i_dac_code,
  input wire logic i_pin_connect,
  input wire logic i_temp,
  input wire logic i_core,
  output logic o_cmp_high
);
  logic [RES_W-1:0] level_d;
  logic [RES_W-1:0] level;
  logic idle_pat = 1'b0;
  // a floating pin would read as garbage, so an open pin gives the inverse level
  assign level_d = i_temp ? LVL_TEMP : (i_core ? LVL_CORE :
                   (i_pin_connect ? LVL_PIN_D : ~LVL_PIN_D));
  assign level = i_chan_sel[0] ? LVL_A : (i_chan_sel[1] ? LVL_B :
                 (i_chan_sel[2] ? LVL_C : level_d));
  always_ff @(posedge i_ref_clk) idle_pat <= ~idle_pat;
  assign o_cmp_high = (i_chan_sel == 4'h0) ? idle_pat : (level >= i_dac_code);
endmodule : sac_analog_model

// >>> test/tb.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: analog model levels at their defaults
// Notes: results only checked at divide-by-16, the slowest converter clock
`timescale 1ns/10ps
module tb
  import sac_pkg::*;
;
  logic i_ref_clk, i_rstn, i_wr, i_rd, i_hw_trig, cmp_high, irq_s, hold_at_start, prev_hold;
  logic [7:0] i_addr, i_wdata, o_rdata, rv;
  logic o_irq, o_power_on, o_sample, o_hold_a, o_hold_b, o_bypass_a, o_bypass_b;
  logic o_ref_core, o_aux_pin_connect, o_aux_temp, o_aux_core;
  logic [3:0] o_chan_sel;
  logic [3:0] prev_sel = 4'h0;
  logic [11:0] o_dac_code;
  logic [3:0] sel_q[$];
  int err_total, comparisons;
  int a_cnt = 0;
  int a_len = 0;
  int s_cnt = 0;
  int s_len = 0;

  sac_top i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_hw_trig(i_hw_trig),
    .i_cmp_high(cmp_high), .o_irq(o_irq), .o_power_on(o_power_on), .o_sample(o_sample),
    .o_chan_sel(o_chan_sel), .o_dac_code(o_dac_code), .o_hold_a(o_hold_a),
    .o_hold_b(o_hold_b), .o_bypass_a(o_bypass_a), .o_bypass_b(o_bypass_b),
    .o_ref_core(o_ref_core), .o_aux_pin_connect(o_aux_pin_connect),
    .o_aux_temp(o_aux_temp), .o_aux_core(o_aux_core));
  sac_analog_model i_ana (.i_ref_clk(i_ref_clk), .i_chan_sel(o_chan_sel),
    .i_dac_code(o_dac_code), .i_pin_connect(o_aux_pin_connect), .i_temp(o_aux_temp),
    .i_core(o_aux_core), .o_cmp_high(cmp_high));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // channel order, hold state before the first channel, channel a length
  always @(posedge i_ref_clk)
  begin
    prev_sel <= o_chan_sel;
    prev_hold <= o_hold_a;
    if (o_chan_sel !== prev_sel && o_chan_sel !== 4'h0)
      sel_q.push_back(o_chan_sel);
    if (prev_sel === 4'h0 && o_chan_sel !== 4'h0)
      hold_at_start <= prev_hold;
    if (o_chan_sel === 4'h1)
      a_cnt <= a_cnt + 1;
    else if (a_cnt != 0)
    begin
      a_len <= a_cnt;
      a_cnt <= 0;
    end
    if (o_chan_sel === 4'h1 && o_sample === 1'b1)
      s_cnt <= s_cnt + 1;
    else if (o_chan_sel !== 4'h1 && s_cnt != 0)
    begin
      s_len <= s_cnt;
      s_cnt <= 0;
    end
  end

  task automatic finish_test();
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // a gap cycle between accesses keeps each strobe assigned once per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    #1 irq_s = o_irq;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk(nm, 12'(exp), 12'(rv));
  endtask : rdc

  // polls go; irq must stay low while go reads 1 and match exp once it clears
  task automatic wait_idle(input logic exp);
    int n;
    n = 0;
    rd(OFS_CONFIG, rv);
    while (rv[CFG_GO] === 1'b1 && n < 1500)
    begin
      chk("irq busy", 12'h0, 12'(irq_s));
      rd(OFS_CONFIG, rv);
      n++;
    end
    chk("go clear", 12'h0, 12'(rv[CFG_GO]));
    chk("irq at clear", 12'(exp), 12'(irq_s));
  endtask : wait_idle

  initial
  begin
    i_rstn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_hw_trig = 1'b0;
    err_total = 0;
    comparisons = 0;
    repeat (4) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rdc("cfg reset", OFS_CONFIG, RST_CONFIG);
    rdc("ctl reset", OFS_CONTROL, RST_CONTROL);
    rdc("chan reset", OFS_CHAN_EN, 8'h00);
    rdc("mask reset", OFS_IRQ_MASK, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    wr(OFS_CONFIG, 8'hef);
    rdc("cfg rw", OFS_CONFIG, 8'hab);
    chk("power on", 12'h1, 12'(o_power_on));
    wr(OFS_CONFIG, 8'h00);
    chk("power off", 12'h0, 12'(o_power_on));
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_CONTROL, {k[1:0], 6'h08});
      chk("pin", 12'(k < 2), 12'(o_aux_pin_connect));
      chk("temp", 12'(k == 2), 12'(o_aux_temp));
      chk("core", 12'(k == 3), 12'(o_aux_core));
      chk("ref", 12'h1, 12'(o_ref_core));
      chk("bypass a", 12'h1, 12'(o_bypass_a));
      chk("bypass b", 12'h1, 12'(o_bypass_b));
    end
    rdc("ctl rw", OFS_CONTROL, 8'hc8);
    wr(OFS_CONTROL, 8'h20);
    chk("ref main", 12'h0, 12'(o_ref_core));
    chk("no bypass a", 12'h0, 12'(o_bypass_a));
    wr(OFS_CHAN_EN, 8'h03);
    wr(OFS_CONFIG, 8'h80);
    repeat (2000) @(posedge i_ref_clk);
    // faster dividers exceed the analog clock limit, so only timing is judged there
    for (int d = 0; d < 4; d++)
    begin
      wr(OFS_CONFIG, {6'h24, d[1:0]});
      wait_idle(1'b0);
      chk("chan time", 12'(32 << (d + 1)), 12'(a_len));
      chk("sample time", 12'((int'(SAR_SEED) + 1) << (d + 1)), 12'(s_len));
      chk("hold first", 12'h1, 12'(hold_at_start));
    end
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_CHAN_EN, 8'h0b);
    wr(OFS_CONTROL, 8'h30);
    sel_q.delete();
    wr(OFS_CONFIG, 8'hbb);
    wait_idle(1'b1);
    chk("hold b idle", 12'h0, 12'(o_hold_b));
    chk("seq len", 12'h3, 12'(sel_q.size()));
    chk("seq order", 12'h128, {sel_q[0], sel_q[1], sel_q[2]});
    rdc("status set", OFS_IRQ_STATUS, 8'h01);
    chk("irq cleared", 12'h0, 12'(o_irq));
    rdc("status clr", OFS_IRQ_STATUS, 8'h00);
    rdc("a high msb", 8'hc4, 8'h5a);
    rdc("a low msb", 8'hc5, 8'h30);
    rdc("b high msb", 8'hc6, 8'hc7);
    rdc("b low msb", 8'hc7, 8'he0);
    wr(OFS_CONFIG, 8'ha3);
    rdc("a high lsb", 8'hc4, 8'h05);
    rdc("a low lsb", 8'hc5, 8'ha3);
    rdc("b high lsb", 8'hc6, 8'h0c);
    rdc("b low lsb", 8'hc7, 8'h7e);
    rdc("c high lsb", 8'hc8, 8'h00);
    rdc("d high lsb", 8'hca, 8'h02);
    rdc("d low lsb", 8'hcb, 8'h22);
    wr(OFS_CONFIG, 8'h93);
    wait_idle(1'b0);
    rdc("no irq en", OFS_IRQ_STATUS, 8'h00);
    wr(OFS_IRQ_MASK, 8'h00);
    wr(OFS_CONFIG, 8'hb3);
    wait_idle(1'b0);
    rdc("masked status", OFS_IRQ_STATUS, 8'h01);
    sel_q.delete();
    @(posedge i_ref_clk);
    i_hw_trig <= 1'b1;
    @(posedge i_ref_clk);
    i_hw_trig <= 1'b0;
    wr(OFS_CONFIG, 8'h93);
    wait_idle(1'b0);
    chk("one sequence", 12'h3, 12'(sel_q.size()));
    rdc("no restart", OFS_CONFIG, 8'h83);
    wr(OFS_CONFIG, 8'h93);
    repeat (100) @(posedge i_ref_clk);
    wr(OFS_CONFIG, 8'h03);
    @(posedge i_ref_clk);
    #1;
    chk("abort sel", 12'h0, 12'(o_chan_sel));
    rdc("abort go", OFS_CONFIG, 8'h03);
    rdc("abort status", OFS_IRQ_STATUS, 8'h00);
    finish_test();
  end

  // the tests take about 10000 cycles
  initial
  begin
    repeat (60000) @(posedge i_ref_clk);
    err_total++;
    finish_test();
  end
endmodule : tb
